//--- rtl/ura_decode.sv
/*
 * Register access decoder of one UART channel behind the 8-bit host bus.
 * Assumes address and data pins are stable for the whole strobe and that the
 * normal channel registers answer chan_rdata_i one cycle after chan_rd_o.
 */
// Overview of operation
// - Line control 0x80 maps offsets 0 and 1 to the divisor bytes.
// - Line control 0xBF maps offset 6 to pause one and 4 to resume one.
// - Line control 0xBF maps offset 7 to pause two and 5 to resume two.
// - Line control 0xBF maps offset 2 to the enhanced feature register.
// - Enhanced set, line control 0x00, modem bit 6 map offset 6 to threshold.
// - The same conditions map offset 7 to the trigger level register, except reads that return FIFO ready status.
// - With modem bit 2 set, bit 4 clear and line bit 7 clear, reading offset 7 returns FIFO ready status.
// - Outside the 0xBF set, offset 4 is the modem control register.
// - Threshold and trigger writes only when feature bit 4 and modem bit 6.
// - FIFO ready is read-only, needs modem bit 2 and loopback off.
`timescale 1ns/100ps
module ura_decode #(
  parameter int DATA_W = 8
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [2:0] addr_i,
  input wire logic [DATA_W-1:0] data_i,
  output logic [DATA_W-1:0] data_o,
  output logic data_oe_o,
  input wire logic [DATA_W-1:0] fifo_ready_view_i,
  input wire logic [DATA_W-1:0] chan_rdata_i,
  output logic chan_wr_o,
  output logic chan_rd_o,
  output logic [2:0] chan_addr_o,
  output logic [DATA_W-1:0] chan_wdata_o,
  output logic [DATA_W-1:0] line_control_o,
  output logic [DATA_W-1:0] modem_control_o,
  output logic [DATA_W-1:0] enhanced_feature_control_o
);

  if (DATA_W != 8) begin : g_bad_width
    $error("ura_decode supports only an 8-bit bus");
  end

  // ***************************************************************
  // Decode functions.
  // ***************************************************************
  function automatic ura_pkg::ura_tgt_e ura_target(input logic [2:0] a, input logic [7:0] line,
      input logic [7:0] feat, input logic [7:0] modem, input logic is_rd);
    logic bf;
    logic alt;
    logic thr;
    logic rdy;
    bf = (line == ura_pkg::LINE_CTRL_ENH_SET);
    alt = line[ura_pkg::LINE_CTRL_ALT_BIT];
    thr = !alt && feat[ura_pkg::FEATURE_ENABLE_BIT] && modem[ura_pkg::MODEM_THRESH_BIT];
    rdy = !alt && modem[ura_pkg::MODEM_READY_BIT] && !modem[ura_pkg::MODEM_LOOP_BIT];
    case (a)
      ura_pkg::OFS_DIV_LOW, ura_pkg::OFS_DIV_HIGH: begin
        ura_target = alt ? ura_pkg::TGT_MEM : ura_pkg::TGT_CHAN;
      end
      ura_pkg::OFS_ENH_FEATURE: begin
        ura_target = bf ? ura_pkg::TGT_FEATURE : ura_pkg::TGT_CHAN;
      end
      ura_pkg::OFS_LINE_CTRL: begin
        ura_target = ura_pkg::TGT_LINE;
      end
      ura_pkg::OFS_MODEM_CTRL: begin
        ura_target = bf ? ura_pkg::TGT_MEM : ura_pkg::TGT_MODEM;
      end
      ura_pkg::OFS_RESUME_TWO: begin
        ura_target = bf ? ura_pkg::TGT_MEM : ura_pkg::TGT_CHAN;
      end
      ura_pkg::OFS_THRESHOLD: begin
        ura_target = (bf || thr) ? ura_pkg::TGT_MEM : ura_pkg::TGT_CHAN;
      end
      ura_pkg::OFS_TRIGGER: begin
        if (bf) begin
          ura_target = ura_pkg::TGT_MEM;
        end else if (is_rd && rdy) begin
          ura_target = ura_pkg::TGT_READY;
        end else if (thr) begin
          ura_target = ura_pkg::TGT_MEM;
        end else begin
          ura_target = ura_pkg::TGT_CHAN;
        end
      end
      default: begin
        ura_target = ura_pkg::TGT_CHAN;
      end
    endcase
  endfunction : ura_target

  function automatic logic [2:0] ura_mem_index(input logic [2:0] a, input logic [7:0] line);
    if (line[ura_pkg::LINE_CTRL_ALT_BIT]) begin
      ura_mem_index = a;
    end else if (a == ura_pkg::OFS_THRESHOLD) begin
      ura_mem_index = ura_pkg::MEM_IDX_THRESHOLD;
    end else begin
      ura_mem_index = ura_pkg::MEM_IDX_TRIGGER;
    end
  endfunction : ura_mem_index

  // ***************************************************************
  // Pin synchronisers.
  // ***************************************************************
  // The whole bus passes the same three stages so that address and data stay
  // aligned with the filtered strobes.
  localparam int BUS_W = 3 + 3 + DATA_W;
  logic [BUS_W-1:0] sync [ura_pkg::SYNC_STAGES];
  logic [BUS_W-1:0] bus_stable;
  logic [BUS_W-1:0] next_bus_stable;

  always_comb begin
    for (int b = 0; b < BUS_W; b++) begin
      next_bus_stable[b] = (sync[1][b] == sync[2][b]) ? sync[2][b] : bus_stable[b];
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int s = 0; s < ura_pkg::SYNC_STAGES; s++) begin
        sync[s] <= {3'h7, {(BUS_W - 3){1'b0}}};
      end
      bus_stable <= {3'h7, {(BUS_W - 3){1'b0}}};
    end else begin
      sync[0] <= {cs_n_i, rd_n_i, wr_n_i, addr_i, data_i};
      sync[1] <= sync[0];
      sync[2] <= sync[1];
      bus_stable <= next_bus_stable;
    end
  end

  logic cs_n_s;
  logic rd_n_s;
  logic wr_n_s;
  logic [2:0] addr_s;
  logic [DATA_W-1:0] data_s;
  logic rd_lvl;
  logic wr_lvl;
  logic wr_lvl_q;
  logic rd_start;
  logic wr_start;

  assign {cs_n_s, rd_n_s, wr_n_s, addr_s, data_s} = bus_stable;
  assign rd_lvl = !cs_n_s && !rd_n_s;
  assign wr_lvl = !cs_n_s && !wr_n_s;
  assign wr_start = wr_lvl && !wr_lvl_q;

  // ***************************************************************
  // Control registers and access sequencing.
  // ***************************************************************
  ura_pkg::ura_state_e state;
  ura_pkg::ura_state_e next_state;
  ura_pkg::ura_tgt_e rd_tgt;
  ura_pkg::ura_tgt_e next_rd_tgt;
  ura_pkg::ura_tgt_e wr_tgt;
  logic [7:0] next_line_control;
  logic [7:0] next_modem_control;
  logic [7:0] next_feature_control;
  logic next_mem_we;
  logic next_mem_re;
  logic mem_we;
  logic mem_re;
  logic [2:0] mem_addr;
  logic [2:0] next_mem_addr;
  logic [DATA_W-1:0] mem_wdata;
  logic [DATA_W-1:0] mem_rdata;
  logic next_chan_wr;
  logic next_chan_rd;
  logic [2:0] next_chan_addr;
  logic [DATA_W-1:0] next_chan_wdata;
  logic [DATA_W-1:0] next_data;
  logic next_oe;

  assign rd_start = rd_lvl && (state == ura_pkg::ST_IDLE);
  assign wr_tgt = ura_target(addr_s, line_control_o, enhanced_feature_control_o,
      modem_control_o, 1'b0);

  always_comb begin
    next_state = state;
    next_rd_tgt = rd_tgt;
    next_line_control = line_control_o;
    next_modem_control = modem_control_o;
    next_feature_control = enhanced_feature_control_o;
    next_mem_we = 1'b0;
    next_mem_re = 1'b0;
    next_mem_addr = mem_addr;
    next_chan_wr = 1'b0;
    next_chan_rd = 1'b0;
    next_chan_addr = chan_addr_o;
    next_chan_wdata = chan_wdata_o;
    next_data = data_o;
    next_oe = data_oe_o;
    if (wr_start) begin
      next_mem_addr = ura_mem_index(addr_s, line_control_o);
      next_chan_addr = addr_s;
      next_chan_wdata = data_s;
      case (wr_tgt)
        ura_pkg::TGT_LINE: next_line_control = data_s;
        ura_pkg::TGT_FEATURE: next_feature_control = data_s;
        ura_pkg::TGT_MODEM: begin
          // The upper modem bits stay locked unless enhanced functions are on.
          if (enhanced_feature_control_o[ura_pkg::FEATURE_ENABLE_BIT]) begin
            next_modem_control = data_s;
          end else begin
            next_modem_control = (modem_control_o & ura_pkg::MODEM_PROTECT_MASK)
                | (data_s & ~ura_pkg::MODEM_PROTECT_MASK);
          end
        end
        ura_pkg::TGT_MEM: next_mem_we = 1'b1;
        default: next_chan_wr = 1'b1;
      endcase
    end
    case (state)
      ura_pkg::ST_IDLE: begin
        next_oe = 1'b0;
        if (rd_start) begin
          next_rd_tgt = ura_target(addr_s, line_control_o, enhanced_feature_control_o,
              modem_control_o, 1'b1);
          next_mem_addr = ura_mem_index(addr_s, line_control_o);
          next_chan_addr = addr_s;
          next_mem_re = 1'b1;
          next_chan_rd = (next_rd_tgt == ura_pkg::TGT_CHAN);
          next_state = ura_pkg::ST_WAIT1;
        end
      end
      ura_pkg::ST_WAIT1: begin
        next_state = ura_pkg::ST_WAIT2;
      end
      ura_pkg::ST_WAIT2: begin
        case (rd_tgt)
          ura_pkg::TGT_LINE: next_data = line_control_o;
          ura_pkg::TGT_MODEM: next_data = modem_control_o;
          ura_pkg::TGT_FEATURE: next_data = enhanced_feature_control_o;
          ura_pkg::TGT_MEM: next_data = mem_rdata;
          ura_pkg::TGT_READY: next_data = fifo_ready_view_i;
          default: next_data = chan_rdata_i;
        endcase
        next_oe = 1'b1;
        next_state = ura_pkg::ST_HOLD;
      end
      ura_pkg::ST_HOLD: begin
        if (!rd_lvl) begin
          next_oe = 1'b0;
          next_state = ura_pkg::ST_IDLE;
        end
      end
      default: begin
        next_oe = 1'b0;
        next_state = ura_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= ura_pkg::ST_IDLE;
      rd_tgt <= ura_pkg::TGT_CHAN;
      wr_lvl_q <= 1'b0;
      line_control_o <= ura_pkg::LINE_CTRL_RESET;
      modem_control_o <= ura_pkg::MODEM_CTRL_RESET;
      enhanced_feature_control_o <= ura_pkg::FEATURE_RESET;
      mem_we <= 1'b0;
      mem_re <= 1'b0;
      mem_addr <= 3'h0;
      mem_wdata <= ura_pkg::MEM_RESET;
      chan_wr_o <= 1'b0;
      chan_rd_o <= 1'b0;
      chan_addr_o <= 3'h0;
      chan_wdata_o <= ura_pkg::MEM_RESET;
      data_o <= ura_pkg::MEM_RESET;
      data_oe_o <= 1'b0;
    end else begin
      state <= next_state;
      rd_tgt <= next_rd_tgt;
      wr_lvl_q <= wr_lvl;
      line_control_o <= next_line_control;
      modem_control_o <= next_modem_control;
      enhanced_feature_control_o <= next_feature_control;
      mem_we <= next_mem_we;
      mem_re <= next_mem_re;
      mem_addr <= next_mem_addr;
      mem_wdata <= next_chan_wdata;
      chan_wr_o <= next_chan_wr;
      chan_rd_o <= next_chan_rd;
      chan_addr_o <= next_chan_addr;
      chan_wdata_o <= next_chan_wdata;
      data_o <= next_data;
      data_oe_o <= next_oe;
    end
  end

  // ***************************************************************
  // Alternate register bank.
  // ***************************************************************
  ura_regmem #(
    .WIDTH(DATA_W),
    .DEPTH(ura_pkg::MEM_DEPTH)
  ) u_regmem (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .we_i(mem_we),
    .waddr_i(mem_addr),
    .wdata_i(mem_wdata),
    .re_i(mem_re),
    .raddr_i(mem_addr),
    .rdata_o(mem_rdata)
  );

endmodule : ura_decode

//--- common/ura_pkg.sv
/*
 * Constants and types for the register access decoder of one UART channel.
 * Assumes a three-bit register offset and an 8-bit data path.
 */
package ura_pkg;

  // ***************************************************************
  // Register offsets.
  // ***************************************************************
  localparam logic [2:0] OFS_DIV_LOW = 3'h0;
  localparam logic [2:0] OFS_DIV_HIGH = 3'h1;
  localparam logic [2:0] OFS_ENH_FEATURE = 3'h2;
  localparam logic [2:0] OFS_LINE_CTRL = 3'h3;
  localparam logic [2:0] OFS_MODEM_CTRL = 3'h4;
  localparam logic [2:0] OFS_RESUME_ONE = 3'h4;
  localparam logic [2:0] OFS_RESUME_TWO = 3'h5;
  localparam logic [2:0] OFS_PAUSE_ONE = 3'h6;
  localparam logic [2:0] OFS_THRESHOLD = 3'h6;
  localparam logic [2:0] OFS_PAUSE_TWO = 3'h7;
  localparam logic [2:0] OFS_TRIGGER = 3'h7;
  localparam logic [2:0] OFS_READY = 3'h7;

  // ***************************************************************
  // Selector values and field positions.
  // ***************************************************************
  localparam logic [7:0] LINE_CTRL_ENH_SET = 8'hBF;
  localparam logic [7:0] LINE_CTRL_DIV_SET = 8'h80;
  localparam int LINE_CTRL_ALT_BIT = 7;
  localparam int FEATURE_ENABLE_BIT = 4;
  localparam int MODEM_READY_BIT = 2;
  localparam int MODEM_LOOP_BIT = 4;
  localparam int MODEM_THRESH_BIT = 6;
  localparam logic [7:0] MODEM_PROTECT_MASK = 8'hE0;

  // ***************************************************************
  // Reset values.
  // ***************************************************************
  localparam logic [7:0] LINE_CTRL_RESET = 8'h00;
  localparam logic [7:0] MODEM_CTRL_RESET = 8'h00;
  localparam logic [7:0] FEATURE_RESET = 8'h00;
  localparam logic [7:0] MEM_RESET = 8'h00;

  // ***************************************************************
  // Alternate register bank slots and depth, pin synchroniser stages.
  // ***************************************************************
  localparam logic [2:0] MEM_IDX_THRESHOLD = 3'h2;
  localparam logic [2:0] MEM_IDX_TRIGGER = 3'h3;
  localparam int MEM_DEPTH = 8;
  localparam int SYNC_STAGES = 3;

  typedef enum logic [6:0] {
    TGT_CHAN = 7'h01,
    TGT_LINE = 7'h02,
    TGT_MODEM = 7'h04,
    TGT_FEATURE = 7'h08,
    TGT_MEM = 7'h10,
    TGT_READY = 7'h20
  } ura_tgt_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WAIT1 = 4'h2,
    ST_WAIT2 = 4'h4,
    ST_HOLD = 4'h8
  } ura_state_e;

endpackage : ura_pkg

//--- rtl/ura_regmem.sv
/*
 * Small register bank holding divisor, flow characters, threshold and trigger.
 * Assumes one write or one read per cycle; read data appear one edge later.
 */
`timescale 1ns/100ps
module ura_regmem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = ura_pkg::MEM_DEPTH
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic we_i,
  input wire logic [$clog2(DEPTH)-1:0] waddr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic re_i,
  input wire logic [$clog2(DEPTH)-1:0] raddr_i,
  output logic [WIDTH-1:0] rdata_o
);

  if (WIDTH != 8 || DEPTH != 8) begin : g_bad_size
    $error("ura_regmem supports only an 8 by 8 bank");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_rdata;

  always_comb begin
    next_rdata = rdata_o;
    if (re_i) begin
      next_rdata = mem[raddr_i];
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= ura_pkg::MEM_RESET;
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= ura_pkg::MEM_RESET;
      end
    end else begin
      rdata_o <= next_rdata;
      if (we_i) begin
        mem[waddr_i] <= wdata_i;
      end
    end
  end

endmodule : ura_regmem

//--- verification/ura_decode_properties.sv
/* Checker for the register access decoder, bound to its ports.
   Assumes a host that holds each strobe low until the access completes. */
`timescale 1ns/100ps
module ura_decode_properties (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] data_o,
  input wire logic data_oe_o,
  input wire logic [7:0] fifo_ready_view_i,
  input wire logic chan_wr_o,
  input wire logic [7:0] line_control_o,
  input wire logic [7:0] modem_control_o,
  input wire logic [7:0] enhanced_feature_control_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);

  property p_wr_pulse;
    chan_wr_o |=> !chan_wr_o;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("channel write longer than one cycle");
  property p_wr_cause;
    chan_wr_o |-> !wr_n_i && !cs_n_i && !$past(wr_n_i, 2);
  endproperty
  a_wr_cause: assert property (p_wr_cause) else $error("channel write without strobe");
  property p_div_not_chan;
    chan_wr_o && addr_i inside {3'h0, 3'h1} |-> !line_control_o[7];
  endproperty
  a_div_not_chan: assert property (p_div_not_chan) else $error("divisor access sent out");
  property p_efr_gate;
    $changed(enhanced_feature_control_o) |-> line_control_o == 8'hBF && addr_i == 3'h2;
  endproperty
  a_efr_gate: assert property (p_efr_gate) else $error("feature register changed outside set");
  property p_mcr_protect;
    $changed(modem_control_o[7:5]) |-> $past(enhanced_feature_control_o[4]);
  endproperty
  a_mcr_protect: assert property (p_mcr_protect) else $error("protected modem bits changed");
  property p_mcr_write;
    $changed(modem_control_o) |-> !wr_n_i && addr_i == 3'h4 && line_control_o != 8'hBF;
  endproperty
  a_mcr_write: assert property (p_mcr_write) else $error("modem control changed wrongly");
  property p_lcr_write;
    $changed(line_control_o) |-> !wr_n_i && !cs_n_i && addr_i == 3'h3;
  endproperty
  a_lcr_write: assert property (p_lcr_write) else $error("line control changed wrongly");
  property p_ready;
    $rose(data_oe_o) && addr_i == 3'h7 && modem_control_o[2] && !modem_control_o[4]
      && !line_control_o[7]
      |-> data_o == fifo_ready_view_i;
  endproperty
  a_ready: assert property (p_ready) else $error("ready status not returned");
  property p_oe_release;
    $rose(rd_n_i) |-> ##[1:6] !data_oe_o;
  endproperty
  a_oe_release: assert property (p_oe_release) else $error("read data held too long");

  c_ready: cover property ($rose(data_oe_o) && addr_i == 3'h7 && modem_control_o[2]);
  c_chan_wr: cover property (chan_wr_o);
  c_efr: cover property ($changed(enhanced_feature_control_o));
endmodule : ura_decode_properties

//--- verification/ura_host.sv
/* Host processor model driving the parallel bus pins.
   Assumes calls come one at a time from the bench. */
`timescale 1ns/100ps
module ura_host (
  input wire logic core_clk_i,
  input wire logic data_oe_i,
  input wire logic [7:0] rdata_i,
  output logic cs_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic [2:0] addr_o,
  output logic [7:0] data_o
);
  initial begin
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    addr_o = 3'h0;
    data_o = 8'h00;
  end

  // Strobes outlast the pin filter; data is inverted after release so it never looks held.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    addr_o = a;
    data_o = d;
    cs_n_o = 1'b0;
    wr_n_o = 1'b0;
    repeat (7) @(negedge core_clk_i);
    cs_n_o = 1'b1;
    wr_n_o = 1'b1;
    data_o = ~d;
    repeat (4) @(negedge core_clk_i);
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    int n;
    n = 0;
    @(negedge core_clk_i);
    addr_o = a;
    cs_n_o = 1'b0;
    rd_n_o = 1'b0;
    do begin
      @(negedge core_clk_i);
      n++;
    end while (data_oe_i !== 1'b1 && n < 20);
    d = (n < 20) ? rdata_i : 8'hxx;
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    repeat (6) @(negedge core_clk_i);
  endtask : rd

  task automatic open_thr(output logic [7:0] l, output logic [7:0] e, output logic [7:0] m);
    rd(3'h3, l);
    wr(3'h3, 8'hBF);
    rd(3'h2, e);
    wr(3'h2, e | 8'h10);
    wr(3'h3, 8'h00);
    rd(3'h4, m);
    wr(3'h4, m | 8'h40);
  endtask : open_thr

  task automatic close_thr(input logic [7:0] l, input logic [7:0] e, input logic [7:0] m);
    wr(3'h3, 8'hBF);
    wr(3'h2, e);
    wr(3'h3, l);
    wr(3'h4, m);
  endtask : close_thr
endmodule : ura_host

//--- verification/ura_decode_tb.sv
/* Self-checking bench for the register access decoder.
   Assumes the host model drives the pins and a channel model answers here. */
`timescale 1ns/100ps
module ura_decode_tb;
  logic core_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic cs_n_i, rd_n_i, wr_n_i, data_oe_o, chan_wr_o, chan_rd_o;
  logic [2:0] addr_i, chan_addr_o;
  logic [7:0] data_i, data_o, chan_wdata_o, s_line, s_feat, s_modem;
  logic [7:0] fifo_ready_view_i = 8'h5A;
  logic [7:0] chan_rdata_i = 8'h00;
  logic [7:0] line_control_o, modem_control_o, enhanced_feature_control_o;
  logic [7:0] chan_mem [8];
  int errors = 0;
  int comparisons = 0;

  always #2.5 core_clk_i = ~core_clk_i;

  ura_decode dut_u (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .cs_n_i(cs_n_i),
    .rd_n_i(rd_n_i),
    .wr_n_i(wr_n_i),
    .addr_i(addr_i),
    .data_i(data_i),
    .data_o(data_o),
    .data_oe_o(data_oe_o),
    .fifo_ready_view_i(fifo_ready_view_i),
    .chan_rdata_i(chan_rdata_i),
    .chan_wr_o(chan_wr_o),
    .chan_rd_o(chan_rd_o),
    .chan_addr_o(chan_addr_o),
    .chan_wdata_o(chan_wdata_o),
    .line_control_o(line_control_o),
    .modem_control_o(modem_control_o),
    .enhanced_feature_control_o(enhanced_feature_control_o)
  );
  ura_host host_u (.core_clk_i(core_clk_i), .data_oe_i(data_oe_o), .rdata_i(data_o),
    .cs_n_o(cs_n_i), .rd_n_o(rd_n_i), .wr_n_o(wr_n_i), .addr_o(addr_i), .data_o(data_i));

  // Normal channel registers answer on the falling edge, well before the decoder samples.
  always @(negedge core_clk_i) begin
    if (chan_wr_o) chan_mem[chan_addr_o] <= chan_wdata_o;
    if (chan_rd_o) chan_rdata_i <= chan_mem[chan_addr_o];
  end

  task automatic end_of_test;
    if (errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rc(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host_u.rd(a, d);
    chk(d, exp);
  endtask : rc

  initial begin
    repeat (3) @(negedge core_clk_i);
    rstn_i = 1'b1;
    host_u.rd(3'h3, s_line);
    host_u.wr(3'h3, 8'h80);
    host_u.wr(3'h0, 8'h12);
    host_u.wr(3'h1, 8'h34);
    rc(3'h0, 8'h12);
    rc(3'h1, 8'h34);
    host_u.wr(3'h3, s_line);
    host_u.wr(3'h0, 8'h55);
    rc(3'h0, 8'h55);
    chk(chan_mem[0], 8'h55);
    host_u.wr(3'h3, 8'h80);
    rc(3'h0, 8'h12);
    host_u.wr(3'h3, 8'hBF);
    for (int i = 2; i < 8; i++) if (i != 3) host_u.wr(3'(i), 8'hA0 + 8'(i));
    for (int i = 2; i < 8; i++) if (i != 3) rc(3'(i), 8'hA0 + 8'(i));
    chk(enhanced_feature_control_o, 8'hA2);
    host_u.wr(3'h3, s_line);
    chk(line_control_o, 8'h00);
    // Feature bit 4 is clear here, so the top modem bits must not take the write.
    host_u.wr(3'h4, 8'hE4);
    chk(modem_control_o, 8'h04);
    host_u.wr(3'h6, 8'h77);
    rc(3'h6, 8'h77);
    rc(3'h7, 8'h5A);
    host_u.open_thr(s_line, s_feat, s_modem);
    chk(modem_control_o, 8'h44);
    host_u.wr(3'h6, 8'hC6);
    host_u.wr(3'h7, 8'hC7);
    rc(3'h6, 8'hC6);
    fifo_ready_view_i = 8'h3C;
    rc(3'h7, 8'h3C);
    host_u.wr(3'h4, 8'h54);
    rc(3'h7, 8'hC7);
    host_u.close_thr(s_line, s_feat, s_modem);
    chk(enhanced_feature_control_o, 8'hA2);
    chk(line_control_o, 8'h00);
    chk(modem_control_o, 8'h44);
    host_u.wr(3'h6, 8'h99);
    rc(3'h6, 8'h99);
    rstn_i = 1'b0;
    @(negedge core_clk_i);
    chk(modem_control_o, 8'h00);
    rstn_i = 1'b1;
    rc(3'h4, 8'h00);
    end_of_test();
  end

  initial begin
    repeat (8000) @(posedge core_clk_i);
    errors++;
    end_of_test();
  end
endmodule : ura_decode_tb

bind ura_decode ura_decode_properties chk_u (
  .core_clk_i(core_clk_i),
  .rstn_i(rstn_i),
  .cs_n_i(cs_n_i),
  .rd_n_i(rd_n_i),
  .wr_n_i(wr_n_i),
  .addr_i(addr_i),
  .data_o(data_o),
  .data_oe_o(data_oe_o),
  .fifo_ready_view_i(fifo_ready_view_i),
  .chan_wr_o(chan_wr_o),
  .line_control_o(line_control_o),
  .modem_control_o(modem_control_o),
  .enhanced_feature_control_o(enhanced_feature_control_o)
);
